// *** hw/tcc_top.v ***
// Purpose: status and control of timer channel one with apb registers
// Assumes: counter inputs come from logic on clk; channel pin is asynchronous
// Notes: single clock, pready always high
// Operation
// - capture mode flags active pin edge
// - compare and edge pwm flag counter match
// - center pwm flags every counter match
// - interrupt while flag set and enabled
// - clear flag by read then write zero
// - event between read and write restarts clear
// - writing one to flag does nothing
// - interrupt enable read/write, reset clears both
// - mode select high gives edge pwm
// - mode select low picks capture or compare
// - edge/level field sets polarity per mode
// - edge/level zero releases pin to gpio
// - capture rising, falling or either edge
// - compare none, toggle, clear, set pin
// - pwm 10 high-true, x1 low-true pulses
// - center select forces center pwm mode
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"

module tcc_top #(
  parameter CNT_WIDTH = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // main counter, same clock domain
  input wire [CNT_WIDTH-1:0] main_timer_counter,
  input wire counter_tick,
  input wire counter_down,
  output wire center_aligned_select,
  // channel pin
  input wire chan_pin_in,
  output reg chan_pin_out,
  output wire chan_pin_oe,
  // interrupt
  output wire chan_irq
);

  // register state
  reg flag_reg;
  reg ie_reg;
  reg mshi_reg;
  reg mslo_reg;
  reg [1:0] els_reg;
  reg arm_reg;
  reg [CNT_WIDTH-1:0] value_reg;
  reg cas_reg;
  wire [`TCC_EV_WIDTH-1:0] ev_stat;
  wire [`TCC_EV_WIDTH-1:0] ev_mask;
  wire [`TCC_EV_WIDTH-1:0] ev_stat_next;
  wire [`TCC_EV_WIDTH-1:0] ev_mask_next;
  // pin synchroniser and edge history
  reg pin_s1_reg;
  reg pin_s2_reg;
  reg pin_s3_reg;

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_sc = (paddr == `TCC_OFS_SC);
  wire hit_value = (paddr == `TCC_OFS_VALUE);
  wire hit_modctl = (paddr == `TCC_OFS_MODCTL);
  wire hit_stat = (paddr == `TCC_OFS_IRQ_STAT);
  wire hit_mask = (paddr == `TCC_OFS_IRQ_MASK);
  wire mapped = hit_sc | hit_value | hit_modctl | hit_stat | hit_mask;
  wire wr = access & pwrite & mapped;
  wire rd = access & ~pwrite & mapped;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // mode decode; center select overrides the channel bits
  reg [1:0] mode;
  always @* begin
    if (cas_reg) begin
      mode = `TCC_MODE_CPWM;
    end else if (mshi_reg) begin
      mode = `TCC_MODE_EPWM;
    end else if (mslo_reg) begin
      mode = `TCC_MODE_OC;
    end else begin
      mode = `TCC_MODE_IC;
    end
  end

  assign center_aligned_select = cas_reg;

  // pin released to gpio when field is zero; timer still counts
  wire pin_used = (els_reg != `TCC_ELS_OFF);

  // capture edge detect on synchronised pin only
  wire pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire pin_fall = ~pin_s2_reg & pin_s3_reg;
  reg edge_hit;
  always @* begin
    case (els_reg)
      `TCC_ELS_01: edge_hit = pin_rise;
      `TCC_ELS_10: edge_hit = pin_fall;
      `TCC_ELS_11: edge_hit = pin_rise | pin_fall;
      default: edge_hit = 1'b0;
    endcase
  end

  wire capture_ev = (mode == `TCC_MODE_IC) & edge_hit;
  wire match = counter_tick & (main_timer_counter == value_reg);
  wire match_ev = (mode != `TCC_MODE_IC) & match;
  wire period_start = counter_tick & (main_timer_counter == {CNT_WIDTH{1'b0}}) & ~counter_down;
  wire chan_event = capture_ev | match_ev;

  // flag clear sequence
  wire sc_read = rd & hit_sc;
  wire sc_write = wr & hit_sc;
  wire clear_req = sc_write & arm_reg & ~pwdata[`TCC_SC_FLAG_BIT];

  // two-state clear handshake; only a status read that saw the flag arms it
  localparam CLR_IDLE = 1'b0;
  localparam CLR_ARMED = 1'b1;
  reg flag_next;
  reg arm_next;
  always @* begin
    flag_next = flag_reg;
    arm_next = arm_reg;
    case (arm_reg)
      CLR_IDLE: begin
        if (sc_read & flag_reg) begin
          arm_next = CLR_ARMED;
        end
      end
      CLR_ARMED: begin
        if (clear_req) begin
          flag_next = 1'b0;
          arm_next = CLR_IDLE;
        end else if (sc_write) begin
          arm_next = CLR_IDLE;
        end
      end
      default: arm_next = CLR_IDLE;
    endcase
    // new event wins over clear and restarts the sequence
    if (chan_event) begin
      flag_next = 1'b1;
      arm_next = CLR_IDLE;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
      arm_reg <= CLR_IDLE;
    end else begin
      flag_reg <= flag_next;
      arm_reg <= arm_next;
    end
  end

  // control fields
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ie_reg <= 1'b0;
      mshi_reg <= 1'b0;
      mslo_reg <= 1'b0;
      els_reg <= 2'h0;
      cas_reg <= `TCC_MODCTL_RST;
    end else begin
      if (sc_write) begin
        ie_reg <= pwdata[`TCC_SC_IE_BIT];
        mshi_reg <= pwdata[`TCC_SC_MSHI_BIT];
        mslo_reg <= pwdata[`TCC_SC_MSLO_BIT];
        els_reg <= pwdata[`TCC_SC_ELS_HI:`TCC_SC_ELS_LO];
      end
      if (wr & hit_modctl) begin
        cas_reg <= pwdata[`TCC_MODCTL_CAS_BIT];
      end
    end
  end

  // channel value: capture loads the counter, else software writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_reg <= `TCC_VALUE_RST;
    end else if (capture_ev) begin
      value_reg <= main_timer_counter;
    end else if (wr & hit_value) begin
      value_reg <= pwdata[CNT_WIDTH-1:0];
    end
  end

  // sticky event status and mask, one cell per event; set wins over a same-cycle clear
  localparam [`TCC_EV_WIDTH-1:0] EV_RST = `TCC_EV_RST;
  wire [`TCC_EV_WIDTH-1:0] ev_set = {period_start, match_ev, capture_ev};
  wire wr_stat = wr & hit_stat;
  wire wr_mask = wr & hit_mask;
  genvar ev_i;
  generate
    for (ev_i = 0; ev_i < `TCC_EV_WIDTH; ev_i = ev_i + 1) begin : g_ev
      reg stat_reg;
      reg mask_reg;
      wire stat_next = ev_set[ev_i] | (stat_reg & ~(wr_stat & pwdata[ev_i]));
      wire mask_next = wr_mask ? pwdata[ev_i] : mask_reg;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stat_reg <= EV_RST[ev_i];
          mask_reg <= EV_RST[ev_i];
        end else begin
          stat_reg <= stat_next;
          mask_reg <= mask_next;
        end
      end
      assign ev_stat[ev_i] = stat_reg;
      assign ev_mask[ev_i] = mask_reg;
      assign ev_stat_next[ev_i] = stat_next;
      assign ev_mask_next[ev_i] = mask_next;
    end
  endgenerate

  // request line from a flop fed by next state: no glitches, same cycle as the flag
  wire ie_next = sc_write ? pwdata[`TCC_SC_IE_BIT] : ie_reg;
  wire irq_next = (flag_next & ie_next) | (|(ev_stat_next & ev_mask_next));
  reg irq_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end
  assign chan_irq = irq_reg;

  // pin synchroniser; first stage feeds only the second
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= chan_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // output drive; capture mode and field zero leave the pin undriven
  // enable flop is fed by next state, so it follows the mode bits without a lag
  wire [1:0] els_next = sc_write ? pwdata[`TCC_SC_ELS_HI:`TCC_SC_ELS_LO] : els_reg;
  wire mshi_next = sc_write ? pwdata[`TCC_SC_MSHI_BIT] : mshi_reg;
  wire mslo_next = sc_write ? pwdata[`TCC_SC_MSLO_BIT] : mslo_reg;
  wire cas_next = (wr & hit_modctl) ? pwdata[`TCC_MODCTL_CAS_BIT] : cas_reg;
  wire oe_next = (els_next != `TCC_ELS_OFF) & (cas_next | mshi_next | mslo_next);
  reg oe_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end
  assign chan_pin_oe = oe_reg;

  // high-true when field is 10, low-true when low bit set
  wire low_true = els_reg[0];
  reg pin_next;
  always @* begin
    pin_next = chan_pin_out;
    case (mode)
      `TCC_MODE_OC: begin
        if (match) begin
          case (els_reg)
            `TCC_ELS_01: pin_next = ~chan_pin_out;
            `TCC_ELS_10: pin_next = 1'b0;
            `TCC_ELS_11: pin_next = 1'b1;
            default: pin_next = chan_pin_out;
          endcase
        end
      end
      `TCC_MODE_EPWM: begin
        // match is checked before period start and wins, so a zero value gives no pulse
        if (match) begin
          pin_next = low_true;
        end else if (period_start) begin
          pin_next = ~low_true;
        end
      end
      `TCC_MODE_CPWM: begin
        if (match & ~counter_down) begin
          pin_next = low_true;
        end else if (match & counter_down) begin
          pin_next = ~low_true;
        end
      end
      default: pin_next = chan_pin_out;
    endcase
    if (!pin_used) begin
      pin_next = 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_pin_out <= 1'b0;
    end else begin
      chan_pin_out <= pin_next;
    end
  end

  // read data registered in the setup cycle
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_sc) begin
      rd_mux = {24'h000000, flag_reg, ie_reg, mshi_reg, mslo_reg, els_reg, 2'h0};
    end else if (hit_value) begin
      rd_mux[CNT_WIDTH-1:0] = value_reg;
    end else if (hit_modctl) begin
      rd_mux[`TCC_MODCTL_CAS_BIT] = cas_reg;
    end else if (hit_stat) begin
      rd_mux[`TCC_EV_WIDTH-1:0] = ev_stat;
    end else if (hit_mask) begin
      rd_mux[`TCC_EV_WIDTH-1:0] = ev_mask;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// *** hw/tcc_consts.vh ***
// Purpose: constants of the timer channel one control block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// register byte offsets
`define TCC_OFS_SC 12'h000
`define TCC_OFS_VALUE 12'h004
`define TCC_OFS_MODCTL 12'h008
`define TCC_OFS_IRQ_STAT 12'h00c
`define TCC_OFS_IRQ_MASK 12'h010

// status/control field positions
`define TCC_SC_FLAG_BIT 7
`define TCC_SC_IE_BIT 6
`define TCC_SC_MSHI_BIT 5
`define TCC_SC_MSLO_BIT 4
`define TCC_SC_ELS_HI 3
`define TCC_SC_ELS_LO 2

// module control and event status positions
`define TCC_MODCTL_CAS_BIT 0
`define TCC_EV_CAPTURE_BIT 0
`define TCC_EV_MATCH_BIT 1
`define TCC_EV_PERIOD_BIT 2
`define TCC_EV_WIDTH 3

// reset values
`define TCC_SC_RST 8'h00
`define TCC_VALUE_RST 16'h0000
`define TCC_MODCTL_RST 1'b0
`define TCC_EV_RST 3'h0

// channel modes
`define TCC_MODE_IC 2'h0
`define TCC_MODE_OC 2'h1
`define TCC_MODE_EPWM 2'h2
`define TCC_MODE_CPWM 2'h3

// edge/level select codes
`define TCC_ELS_OFF 2'h0
`define TCC_ELS_01 2'h1
`define TCC_ELS_10 2'h2
`define TCC_ELS_11 2'h3

`endif

// *** testbench/tcc_props.sv ***
// Purpose: port assertions for timer channel one
// Assumes: value shadow is stale after a capture, so compares run first
// Notes: sc and value shadows follow apb writes
`timescale 1ns/10ps
`default_nettype none
module tcc_props #(
  parameter CNT_WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // counter and pin
  input wire logic [CNT_WIDTH-1:0] main_timer_counter,
  input wire logic counter_tick,
  input wire logic counter_down,
  input wire logic center_aligned_select,
  input wire logic chan_pin_out,
  input wire logic chan_pin_oe,
  input wire logic chan_irq
);
  logic [7:0] sc_reg;
  logic [CNT_WIDTH-1:0] val_reg;
  wire logic wr = psel & penable & pwrite;
  wire logic hit = counter_tick && main_timer_counter == val_reg;
  wire logic oc = !center_aligned_select && sc_reg[5:4] == 2'h1;
  wire logic ep = !center_aligned_select && sc_reg[5];
  wire logic [1:0] els = sc_reg[3:2];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sc_reg <= 8'h00;
      val_reg <= '0;
    end else if (wr && paddr == 12'h000) begin
      sc_reg <= pwdata[7:0];
    end else if (wr && paddr == 12'h004) begin
      val_reg <= pwdata[CNT_WIDTH-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  reset_quiet_a: assert property ($rose(rstn) |-> !chan_irq && !chan_pin_oe)
    else $error("outputs active after reset");
  pin_gate_a: assert property (chan_pin_oe == (els != 2'h0 && (center_aligned_select || sc_reg[5:4] != 2'h0)))
    else $error("pin enable wrong");
  gpio_low_a: assert property ((els == 2'h0) [*2] |-> !chan_pin_out)
    else $error("pin driven while released");
  toggle_a: assert property (oc && els == 2'h1 && hit |=> chan_pin_out != $past(chan_pin_out))
    else $error("no toggle on match");
  set_clear_a: assert property (oc && els[1] && hit |=> chan_pin_out == sc_reg[2])
    else $error("compare level wrong");
  edge_pwm_a: assert property (ep && els != 2'h0 && hit |=> chan_pin_out == sc_reg[2])
    else $error("edge pwm level wrong");
  center_pwm_a: assert property (center_aligned_select && els != 2'h0 && hit && !counter_down
    |=> chan_pin_out == sc_reg[2])
    else $error("center pwm level wrong");
  irq_match_a: assert property ((oc || ep || center_aligned_select) && sc_reg[6] && hit |=> chan_irq)
    else $error("no irq after match");
endmodule
bind tcc_top tcc_props #(.CNT_WIDTH(CNT_WIDTH)) i_props (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .main_timer_counter, .counter_tick, .counter_down, .center_aligned_select, .chan_pin_out,
  .chan_pin_oe, .chan_irq);
`default_nettype wire

// *** testbench/tcc_pin_src.sv ***
// Purpose: external signal on the channel pin
// Assumes: pin is asynchronous to clk
// Notes: edges land off the clock edge
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_src (
  // pin
  output logic pin
);
  initial pin = 1'b0;
  task drive(input logic lvl);
    #13 pin = lvl;
  endtask
endmodule
`default_nettype wire

// *** testbench/timer_channel_one_control_test.sv ***
// Purpose: register level tests of timer channel one
// Assumes: pready may be waited on, idle cycle between transfers
// Notes: compare tests run before capture
`timescale 1ns/10ps
`default_nettype none
module timer_channel_one_control_test;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, tk = 0, dn = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [15:0] cnt = 16'hffff;
  wire pready, pslverr, cas, pout, oe, irq, pin;
  wire [31:0] prdata;
  int miscompares = 0, cmp_count = 0;
  tcc_top i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .main_timer_counter(cnt), .counter_tick(tk), .counter_down(dn), .center_aligned_select(cas),
    .chan_pin_in(pin), .chan_pin_out(pout), .chan_pin_oe(oe), .chan_irq(irq));
  tcc_pin_src i_pin (.pin);
  initial forever #25 clk = ~clk;
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("reg", e, rdat);
  endtask
  task tick(input logic [15:0] c, input logic d);
    cnt <= c;
    dn <= d;
    tk <= 1'b1;
    @(posedge clk);
    tk <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(12'h000, 32'h0);
    chk("irq", 0, irq);
    chk("pready", 1, pready);
    $display("test reset done");
    wr(12'h004, 32'h5);
    wr(12'h000, 32'h54);
    tick(16'h5, 0);
    chk("pin", 1, pout);
    chk("irq", 1, irq);
    rdc(12'h000, 32'hd4);
    tick(16'h5, 0);
    chk("pin", 0, pout);
    wr(12'h000, 32'h54);
    rdc(12'h000, 32'hd4);
    wr(12'h000, 32'h54);
    rdc(12'h000, 32'h54);
    chk("irq", 0, irq);
    wr(12'h000, 32'hd4);
    rdc(12'h000, 32'h54);
    for (int e = 0; e < 4; e++) begin
      wr(12'h000, 32'h10 | e << 2);
      tick(16'h5, 0);
      chk("oe", e != 0, oe);
      chk("pin", e[0], pout);
      chk("irq", 0, irq);
      rdc(12'h000, 32'h90 | e << 2);
    end
    $display("test compare done");
    wr(12'h000, 32'h28);
    tick(16'h0, 0);
    chk("pin", 1, pout);
    tick(16'h5, 0);
    chk("pin", 0, pout);
    wr(12'h000, 32'h24);
    tick(16'h5, 0);
    chk("pin", 1, pout);
    wr(12'h008, 32'h1);
    rdc(12'h000, 32'ha4);
    wr(12'h000, 32'h08);
    chk("cas", 1, cas);
    chk("oe", 1, oe);
    tick(16'h5, 0);
    chk("pin", 0, pout);
    tick(16'h5, 1);
    chk("pin", 1, pout);
    rdc(12'h000, 32'h88);
    wr(12'h008, 32'h0);
    $display("test pwm done");
    cnt <= 16'h1234;
    for (int e = 0; e < 4; e++) begin
      xfer(1'b0, 12'h000, 32'h0);
      wr(12'h000, (e % 3 + 1) << 2);
      i_pin.drive(!e[0]);
      repeat (5) @(posedge clk);
      rdc(12'h000, (e % 3 + 1) << 2 | (e != 3 ? 32'h80 : 32'h0));
    end
    rdc(12'h004, 32'h1234);
    chk("irq", 0, irq);
    wr(12'h010, 32'h1);
    chk("irq", 1, irq);
    wr(12'h00c, 32'h1);
    rdc(12'h00c, 32'h6);
    chk("irq", 0, irq);
    wr(12'h00c, 32'h6);
    rdc(12'h00c, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    chk("slverr", 1, err);
    $display("test capture done");
    stop_test;
  end
endmodule
`default_nettype wire
